// >>> srb_shared_bank.sv
// srb_shared_bank: shared register set and lane steering of a four-lane
// retimer, behind the byte-wide register port of the bus slave engine.
// assumes one request per cycle; lane sets answer reads combinationally.
// Functional notes
// - every write to 0xff lands in the select register, never a lane
// - steering bit 2 low sends all reads and writes to the shared set
// - select bits 1:0 name the lane for reads and single-lane writes
// - bits 3 and 2 both set make every write except to 0xff reach all four lanes
// - one address decodes shared or lane by steering bit 2
// - writes to read-only registers or fields are dropped silently
// - strap bits read in 0x00 bits 7:4; bus address is 0x18 plus them
// - 0x04 bit 6 restores shared defaults then clears itself
// - 0x04 bit 5 resets the bus master engine then clears itself
// - setting 0x04 bit 4 forces a configuration load
// - 0x05 bit 7 blocks the power-on configuration load
// - 0x05 bit 4 reads one except while a configuration load runs
// - 0x05 bits 3..0 show lane 0..3 interrupt flags, read-only
// - access kinds read-only, read-write and self-clearing
// - lane reads use the lane in bits 1:0 even while broadcasting
// - reading the select register returns no valid contents
`timescale 1ns/1ps
module srb_shared_bank #(
   // identity values are arbitrary
   parameter logic [2:0] VERSION_CODE = 3'h2,
   parameter logic [4:0] PART_CODE = 5'h0a,
   parameter int LOAD_DLY = srb_pkg::LOAD_DLY_CYC
) (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // register port from the bus slave engine
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   output logic reg_rvalid_o,
   // lane register sets
   output logic [srb_pkg::N_LANES-1:0] lane_wr_o,
   output logic lane_rd_o,
   output logic [7:0] lane_addr_o,
   output logic [7:0] lane_wdata_o,
   input wire logic [8*srb_pkg::N_LANES-1:0] lane_rdata_i,
   input wire logic [srb_pkg::N_LANES-1:0] lane_irq_i,
   // straps and bus address
   input wire logic [3:0] strap_addr_i,
   output logic [6:0] bus_addr_o,
   // bus master engine
   output logic bm_rst_o,
   output logic ee_start_o,
   input wire logic ee_done_i
);
   import srb_pkg::*;

   generate
      if (N_LANES != 4) begin : g_chk
         $error("lane index field serves exactly four lanes");
      end
   endgenerate

   typedef struct packed {
      logic [7:0] sel;
      logic [7:0] rsv2;
      logic [7:0] ctl;
      logic [7:0] stat;
      logic [7:0] rsv6;
      logic [7:0] rsv7;
      logic [3:0] irq;
      logic [3:0] strap;
      logic strap_taken;
      logic [6:0] bus_addr;
      logic rd_pend;
      logic rd_lane;
      logic [1:0] rd_idx;
      logic [7:0] rd_addr;
      logic [7:0] rdata;
      logic rvalid;
      logic [3:0] lane_wr;
      logic lane_rd;
      logic [7:0] lane_addr;
      logic [7:0] lane_wdata;
      logic bm_rst;
      logic force_pls;
   } srb_state_t;

   localparam srb_state_t ST_RST = '{
      sel: SEL_RST,
      rsv2: RSV2_RST, ctl: CTL_RST, stat: STAT_RST,
      rsv6: RSV6_RST, rsv7: RSV7_RST, irq: 4'h0, strap: 4'h0,
      strap_taken: 1'b0, bus_addr: BUS_ADDR_BASE, rd_pend: 1'b0,
      rd_lane: 1'b0, rd_idx: 2'h0, rd_addr: 8'h00, rdata: 8'h00,
      rvalid: 1'b0, lane_wr: 4'h0, lane_rd: 1'b0, lane_addr: 8'h00,
      lane_wdata: 8'h00, bm_rst: 1'b0, force_pls: 1'b0};

   srb_state_t st;
   srb_state_t next_st;
   logic ld_done;
   logic [3:0] irq_rev;
   logic [7:0] lane_pick;
   logic [7:0] shared_rd;
   logic steer;
   logic wr_sel;

   // lane 0 reports in bit 3, lane 3 in bit 0
   genvar gi;
   generate
      for (gi = 0; gi < N_LANES; gi++) begin : g_irq
         assign irq_rev[N_LANES-1-gi] = lane_irq_i[gi];
      end
   endgenerate

   assign lane_pick = lane_rdata_i[{st.rd_idx, 3'b000} +: 8];
   assign steer = st.sel[SEL_STEER_BIT];
   assign wr_sel = reg_wr_i && reg_addr_i == ADDR_SEL;

   // shared read data; undefined addresses read as zero
   always_comb begin
      unique case (st.rd_addr)
         ADDR_STRAP: shared_rd = {st.strap, 4'h0};
         ADDR_VER: shared_rd = {VERSION_CODE, PART_CODE};
         ADDR_RSV2: shared_rd = st.rsv2;
         ADDR_CTL: shared_rd = st.ctl;
         ADDR_STAT: begin
            shared_rd = st.stat & STAT_WR_MASK;
            shared_rd[STAT_DONE_BIT] = ld_done;
            shared_rd[3:0] = st.irq;
         end
         ADDR_RSV6: shared_rd = st.rsv6;
         ADDR_RSV7: shared_rd = st.rsv7;
         ADDR_SEL: shared_rd = READ_NONE;
         default: shared_rd = READ_NONE;
      endcase
   end

   always_comb begin
      next_st = st;
      next_st.lane_wr = 4'h0;
      next_st.lane_rd = 1'b0;
      next_st.bm_rst = 1'b0;
      next_st.force_pls = 1'b0;
      next_st.irq = irq_rev;
      // straps caught once, on the first edge after reset release
      if (!st.strap_taken) begin
         next_st.strap = strap_addr_i;
         next_st.bus_addr = BUS_ADDR_BASE + {3'h0, strap_addr_i};
         next_st.strap_taken = 1'b1;
      end
      // self-clearing actions, one cycle after the bit was written
      if (st.ctl[CTL_BMRST_BIT]) begin
         next_st.ctl[CTL_BMRST_BIT] = 1'b0;
         next_st.bm_rst = 1'b1;
      end
      if (st.ctl[CTL_SOFTRST_BIT]) begin
         // restores every shared default, which also clears the bit
         next_st.sel = SEL_RST;
         next_st.rsv2 = RSV2_RST;
         next_st.ctl = CTL_RST;
         next_st.stat = STAT_RST;
         next_st.rsv6 = RSV6_RST;
         next_st.rsv7 = RSV7_RST;
      end
      // read pipeline, second stage: capture the answer
      next_st.rvalid = st.rd_pend;
      next_st.rd_pend = 1'b0;
      if (st.rd_pend) begin
         next_st.rdata = st.rd_lane ? lane_pick : shared_rd;
      end
      // read pipeline, first stage
      if (reg_rd_i) begin
         next_st.rd_pend = 1'b1;
         next_st.rd_addr = reg_addr_i;
         next_st.rd_idx = st.sel[1:0];
         next_st.rd_lane = steer && reg_addr_i != ADDR_SEL;
         if (steer && reg_addr_i != ADDR_SEL) begin
            next_st.lane_rd = 1'b1;
            next_st.lane_addr = reg_addr_i;
         end
      end
      // writes: the select register captures regardless of steering
      if (wr_sel) begin
         next_st.sel = reg_wdata_i;
      end else if (reg_wr_i && steer) begin
         next_st.lane_addr = reg_addr_i;
         next_st.lane_wdata = reg_wdata_i;
         if (st.sel[SEL_BCAST_BIT]) begin
            next_st.lane_wr = 4'hf;
         end else begin
            next_st.lane_wr = 4'h1 << st.sel[1:0];
         end
      end else if (reg_wr_i) begin
         // read-only addresses fall through and are ignored
         unique case (reg_addr_i)
            ADDR_RSV2: next_st.rsv2 = reg_wdata_i;
            ADDR_CTL: begin
               next_st.ctl = reg_wdata_i;
               next_st.force_pls = reg_wdata_i[CTL_FORCE_BIT]
                  && !st.ctl[CTL_FORCE_BIT];
            end
            ADDR_STAT: next_st.stat = reg_wdata_i & STAT_WR_MASK;
            ADDR_RSV6: next_st.rsv6 = reg_wdata_i;
            ADDR_RSV7: next_st.rsv7 = reg_wdata_i;
            default: next_st.rsv2 = next_st.rsv2;
         endcase
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         st <= ST_RST;
      end else begin
         st <= next_st;
      end
   end

   srb_cfg_loader #(
      .LOAD_DLY(LOAD_DLY)
   ) u_loader (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .force_i(st.force_pls),
      .disable_i(st.stat[STAT_DISABLE_BIT]),
      .abort_i(st.bm_rst),
      .ee_done_i(ee_done_i),
      .ee_start_o(ee_start_o),
      .done_o(ld_done)
   );

   assign reg_rdata_o = st.rdata;
   assign reg_rvalid_o = st.rvalid;
   assign lane_wr_o = st.lane_wr;
   assign lane_rd_o = st.lane_rd;
   assign lane_addr_o = st.lane_addr;
   assign lane_wdata_o = st.lane_wdata;
   assign bus_addr_o = st.bus_addr;
   assign bm_rst_o = st.bm_rst;

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);

   a_sel_always_wr: assert property (
      wr_sel && !st.ctl[CTL_SOFTRST_BIT]
      |=> st.sel == $past(reg_wdata_i) && lane_wr_o == 4'h0)
      else $error("write to 0xff missed the select register");
   a_shared_no_lane: assert property (
      !steer |=> lane_wr_o == 4'h0 && !lane_rd_o)
      else $error("lane access while steering is off");
   a_single_lane_wr: assert property (
      reg_wr_i && !wr_sel && steer && !st.sel[SEL_BCAST_BIT]
      |=> lane_wr_o == (4'h1 << $past(st.sel[1:0]))
          && lane_wdata_o == $past(reg_wdata_i))
      else $error("single lane write went to the wrong lane");
   a_bcast_all_wr: assert property (
      reg_wr_i && !wr_sel && steer && st.sel[SEL_BCAST_BIT]
      |=> lane_wr_o == 4'hf && lane_addr_o == $past(reg_addr_i))
      else $error("broadcast write missed a lane");
   a_strap_readout: assert property (
      reg_rd_i && !steer && reg_addr_i == ADDR_STRAP && st.strap_taken
      |-> ##2 reg_rvalid_o && reg_rdata_o == {st.strap, 4'h0})
      else $error("shared 0x00 read returned wrong data");
   a_ro_strap_kept: assert property (
      reg_wr_i && !steer && reg_addr_i == ADDR_STRAP && st.strap_taken
      |=> $stable(st.strap) && $stable(bus_addr_o))
      else $error("write changed a read-only field");
   a_bus_addr_sum: assert property (
      st.strap_taken |-> bus_addr_o == BUS_ADDR_BASE + {3'h0, st.strap})
      else $error("bus address is not base plus straps");
   a_soft_rst_clear: assert property (
      reg_wr_i && !steer && reg_addr_i == ADDR_CTL
      && reg_wdata_i[CTL_SOFTRST_BIT] ##1 !reg_wr_i
      |=> st.sel == SEL_RST && st.rsv7 == RSV7_RST
          && !st.ctl[CTL_SOFTRST_BIT])
      else $error("shared soft reset did not restore defaults");
   a_bm_rst_pulse: assert property (
      reg_wr_i && !steer && reg_addr_i == ADDR_CTL
      && reg_wdata_i[CTL_BMRST_BIT]
      |-> ##2 bm_rst_o && !st.ctl[CTL_BMRST_BIT])
      else $error("engine reset not pulsed or bit not cleared");
   a_irq_order: assert property (
      1'b1 |=> st.irq == $past(irq_rev))
      else $error("lane interrupt flags out of order");
   a_lane_rd_idx: assert property (
      lane_rd_o |=> reg_rvalid_o && reg_rdata_o == $past(lane_pick))
      else $error("lane read answered from wrong lane");
   a_sel_rd_none: assert property (
      reg_rd_i && reg_addr_i == ADDR_SEL
      |-> ##2 reg_rdata_o == READ_NONE && !$past(lane_rd_o))
      else $error("select register read not invalid");

   c_bcast_wr: cover property (lane_wr_o == 4'hf);
   c_lane_rd: cover property (lane_rd_o ##1 reg_rvalid_o);
   c_soft_rst: cover property (st.ctl[CTL_SOFTRST_BIT] ##1 st.sel == 8'h00);
   c_force_ld: cover property (st.force_pls ##1 ee_start_o);
endmodule // srb_shared_bank

// >>> srb_pkg.sv
// srb_pkg: constants of the shared register bank and lane steering.
// assumes a byte-wide register port from the device's bus slave engine.
package srb_pkg;
   // register offsets
   localparam logic [7:0] ADDR_STRAP = 8'h00;
   localparam logic [7:0] ADDR_VER = 8'h01;
   localparam logic [7:0] ADDR_RSV2 = 8'h02;
   localparam logic [7:0] ADDR_RSV3 = 8'h03;
   localparam logic [7:0] ADDR_CTL = 8'h04;
   localparam logic [7:0] ADDR_STAT = 8'h05;
   localparam logic [7:0] ADDR_RSV6 = 8'h06;
   localparam logic [7:0] ADDR_RSV7 = 8'h07;
   localparam logic [7:0] ADDR_SEL = 8'hff;
   // field positions
   localparam int SEL_BCAST_BIT = 3;
   localparam int SEL_STEER_BIT = 2;
   localparam int CTL_SOFTRST_BIT = 6;
   localparam int CTL_BMRST_BIT = 5;
   localparam int CTL_FORCE_BIT = 4;
   localparam int STAT_DISABLE_BIT = 7;
   localparam int STAT_DONE_BIT = 4;
   localparam int STRAP_LSB = 4;
   localparam logic [7:0] STAT_WR_MASK = 8'he0;
   // reset values
   localparam logic [7:0] SEL_RST = 8'h00;
   localparam logic [7:0] RSV2_RST = 8'h00;
   localparam logic [7:0] CTL_RST = 8'h01;
   localparam logic [7:0] STAT_RST = 8'h00;
   localparam logic [7:0] RSV6_RST = 8'h00;
   localparam logic [7:0] RSV7_RST = 8'h05;
   localparam logic [7:0] READ_NONE = 8'h00;
   localparam logic [6:0] BUS_ADDR_BASE = 7'h18;
   localparam int N_LANES = 4;
   // timing: power-on configuration load waits this long
   localparam int CLK_PERIOD_PS = 5000;
   localparam int LOAD_DLY_NS = 80;
   localparam int LOAD_DLY_CYC =
      (LOAD_DLY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
endpackage

// >>> srb_cfg_loader.sv
// srb_cfg_loader: sequences the configuration load from external memory.
// assumes an external master engine that answers each start with done.
`timescale 1ns/1ps
module srb_cfg_loader #(
   parameter int LOAD_DLY = srb_pkg::LOAD_DLY_CYC
) (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // control from the shared bank
   input wire logic force_i,
   input wire logic disable_i,
   input wire logic abort_i,
   // master engine
   input wire logic ee_done_i,
   output logic ee_start_o,
   output logic done_o
);
   import srb_pkg::*;
   localparam int CW = $clog2(LOAD_DLY + 1);
   localparam logic [CW-1:0] DLY_LAST = CW'(LOAD_DLY - 1);

   generate
      if (LOAD_DLY < 1) begin : g_chk
         $error("load delay must be at least one cycle");
      end
   endgenerate

   typedef enum logic [2:0] {
      LD_WAIT = 3'b001,
      LD_IDLE = 3'b010,
      LD_RUN = 3'b100
   } srb_ld_state_t;

   typedef struct packed {
      srb_ld_state_t fsm;
      logic [CW-1:0] cnt;
      logic start;
      logic done;
   } srb_ld_t;

   localparam srb_ld_t LD_RST = '{fsm: LD_WAIT, cnt: '0, start: 1'b0,
                                  done: 1'b1};
   srb_ld_t st;
   srb_ld_t next_st;

   always_comb begin
      next_st = st;
      next_st.start = 1'b0;
      unique case (st.fsm)
         LD_WAIT: begin
            next_st.cnt = st.cnt + CW'(1);
            if (st.cnt == DLY_LAST) begin
               // power-on load skipped when software disabled it
               if (disable_i) begin
                  next_st.fsm = LD_IDLE;
               end else begin
                  next_st.fsm = LD_RUN;
                  next_st.start = 1'b1;
                  next_st.done = 1'b0;
               end
            end
         end
         LD_IDLE: begin
            if (force_i) begin
               next_st.fsm = LD_RUN;
               next_st.start = 1'b1;
               next_st.done = 1'b0;
            end
         end
         LD_RUN: begin
            if (ee_done_i) begin
               next_st.fsm = LD_IDLE;
               next_st.done = 1'b1;
            end
         end
         default: next_st = LD_RST;
      endcase
      // engine reset abandons a load in flight
      if (abort_i && st.fsm != LD_WAIT) begin
         next_st.fsm = LD_IDLE;
         next_st.start = 1'b0;
         next_st.done = 1'b1;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         st <= LD_RST;
      end else begin
         st <= next_st;
      end
   end

   assign ee_start_o = st.start;
   assign done_o = st.done;

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);

   a_force_starts: assert property (
      st.fsm == LD_IDLE && force_i && !abort_i |=> ee_start_o && !done_o)
      else $error("forced load did not start");
   a_disable_skips: assert property (
      st.fsm == LD_WAIT && st.cnt == DLY_LAST && disable_i
      |=> !ee_start_o && st.fsm == LD_IDLE)
      else $error("disabled power-on load still started");
   a_done_sets: assert property (
      st.fsm == LD_RUN && ee_done_i |=> done_o && !ee_start_o)
      else $error("load done flag not set");
   c_load_run: cover property (ee_start_o ##[1:50] done_o);
endmodule // srb_cfg_loader

// >>> srb_lane_model.sv
// srb_lane_model: stand-in for the four lane register sets.
// assumes registered lane strobes; reads answer combinationally.
`timescale 1ns/1ps
module srb_lane_model (
   // clock
   input wire logic clk_sys_i,
   // lane port from the bank
   input wire logic [3:0] lane_wr_i,
   input wire logic lane_rd_i,
   input wire logic [7:0] lane_addr_i,
   input wire logic [7:0] lane_wdata_i,
   // read data to the bank
   output logic [31:0] lane_rdata_o
);
   logic [7:0] mem [4][256];
   initial begin
      for (int k = 0; k < 4; k++) begin
         for (int a = 0; a < 256; a++) begin
            mem[k][a] = 8'h00;
         end
      end
   end
   always @(posedge clk_sys_i) begin
      for (int k = 0; k < 4; k++) begin
         if (lane_wr_i[k] === 1'b1) begin
            mem[k][lane_addr_i] <= lane_wdata_i;
         end
      end
   end
   // inverted outside a strobe so a stale byte never matches
   always_comb begin
      for (int k = 0; k < 4; k++) begin
         lane_rdata_o[8*k +: 8] = lane_rd_i ? mem[k][lane_addr_i]
            : ~mem[k][lane_addr_i];
      end
   end
endmodule // srb_lane_model

// >>> shared_register_bank_channel_steering_test.sv
// testbench of the shared bank: register port tasks and sequences.
// assumes srb_shared_bank and srb_lane_model; straps 0x5, then 0xa after a second reset.
`timescale 1ns/1ps
module shared_register_bank_channel_steering_test;
   import srb_pkg::*;
   localparam logic [3:0] STRAP = 4'h5;
   localparam logic [7:0] RA [5] = '{8'h02, 8'h04, 8'h05, 8'h06, 8'h07};
   localparam logic [7:0] RV [5] = '{8'h00, 8'h01, 8'h10, 8'h00, 8'h05};
   logic clk_sys_i;
   logic rst_n_i;
   logic reg_wr_i;
   logic reg_rd_i;
   logic [7:0] reg_addr_i;
   logic [7:0] reg_wdata_i;
   logic [7:0] reg_rdata_o;
   logic reg_rvalid_o;
   logic [3:0] lane_wr_o;
   logic lane_rd_o;
   logic [7:0] lane_addr_o;
   logic [7:0] lane_wdata_o;
   logic [31:0] lane_rdata_i;
   logic [3:0] lane_irq_i;
   logic [3:0] strap_addr_i;
   logic [6:0] bus_addr_o;
   logic bm_rst_o;
   logic ee_start_o;
   logic ee_done_i;
   int miscompares;
   int samples_checked;
   int cnt [3];
   int dly;
   srb_shared_bank #(.LOAD_DLY(4)) dut (
      .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
      .lane_wr_o(lane_wr_o), .lane_rd_o(lane_rd_o),
      .lane_addr_o(lane_addr_o), .lane_wdata_o(lane_wdata_o),
      .lane_rdata_i(lane_rdata_i), .lane_irq_i(lane_irq_i),
      .strap_addr_i(strap_addr_i), .bus_addr_o(bus_addr_o),
      .bm_rst_o(bm_rst_o), .ee_start_o(ee_start_o),
      .ee_done_i(ee_done_i));
   srb_lane_model u_lane (
      .clk_sys_i(clk_sys_i), .lane_wr_i(lane_wr_o),
      .lane_rd_i(lane_rd_o), .lane_addr_i(lane_addr_o),
      .lane_wdata_i(lane_wdata_o), .lane_rdata_o(lane_rdata_i));
   initial begin
      clk_sys_i = 1'b0;
      forever #2.5 clk_sys_i = ~clk_sys_i;
   end
   // engine stand-in: a load takes 8 cycles; count pulses
   always @(posedge clk_sys_i) begin
      ee_done_i <= (dly == 1);
      if (ee_start_o === 1'b1) begin
         dly <= 8;
         cnt[0] <= cnt[0] + 1;
      end else if (dly != 0) begin
         dly <= dly - 1;
      end
      if (ee_done_i === 1'b1) begin
         cnt[1] <= cnt[1] + 1;
      end
      if (bm_rst_o === 1'b1) begin
         cnt[2] <= cnt[2] + 1;
      end
   end
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string w, input logic [7:0] e,
      input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", w, e, g);
      end
   endtask
   // idle edge after each write keeps strobes from re-rising at once
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge clk_sys_i);
      reg_wr_i <= 1'b0;
      @(posedge clk_sys_i);
   endtask
   task automatic rdc(input string w, input logic [7:0] a,
      input logic [7:0] e);
      int n;
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge clk_sys_i);
      reg_rd_i <= 1'b0;
      n = 0;
      while (reg_rvalid_o !== 1'b1 && n < 5) begin
         @(posedge clk_sys_i);
         n++;
      end
      if (n == 5) begin
         miscompares++;
         report_and_stop;
      end
      chk(w, e, reg_rdata_o);
   endtask
   task automatic wait_for(input int k, input int n);
      int t;
      t = 0;
      while (cnt[k] < n && t < 40) begin
         @(posedge clk_sys_i);
         t++;
      end
      if (t == 40) begin
         miscompares++;
         report_and_stop;
      end
   endtask
   initial begin
      rst_n_i = 1'b0;
      reg_wr_i = 1'b0;
      reg_rd_i = 1'b0;
      reg_addr_i = 8'h00;
      reg_wdata_i = 8'h00;
      lane_irq_i = 4'h0;
      strap_addr_i = STRAP;
      ee_done_i = 1'b0;
      miscompares = 0;
      samples_checked = 0;
      dly = 0;
      cnt = '{0, 0, 0};
      repeat (8) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      @(posedge clk_sys_i);
      wait_for(1, 1);
      rdc("strap", ADDR_STRAP, {STRAP, 4'h0});
      chk("bus_addr", {1'b0, 7'h18 + 7'(STRAP)}, {1'b0, bus_addr_o});
      rdc("ident", ADDR_VER, {3'h2, 5'h0a});
      for (int i = 0; i < 5; i++) begin
         // reserved, control and status bytes read for their reset defaults
         rdc("default", RA[i], RV[i]);
      end
      wr(ADDR_VER, 8'hff);
      wr(ADDR_STRAP, 8'hff);
      wr(ADDR_STAT, 8'h1f);
      rdc("ro_ver", ADDR_VER, {3'h2, 5'h0a});
      rdc("ro_strap", ADDR_STRAP, {STRAP, 4'h0});
      rdc("ro_stat", ADDR_STAT, 8'h10);
      wr(ADDR_RSV2, 8'ha5);
      rdc("rw_rsv2", ADDR_RSV2, 8'ha5);
      for (int k = 0; k < 4; k++) begin
         lane_irq_i <= 4'(1 << k);
         @(posedge clk_sys_i);
         rdc("irq", ADDR_STAT, 8'h10 | 8'(1 << (3 - k)));
      end
      lane_irq_i <= 4'h0;
      for (int k = 0; k < 4; k++) begin
         wr(ADDR_SEL, 8'h04 | 8'(k));
         wr(8'h00, 8'h30 + 8'(k));
         rdc("lane_rd", 8'h00, 8'h30 + 8'(k));
         rdc("sel_rd", ADDR_SEL, 8'h00);
         chk("lane_wr", 8'h30 + 8'(k), u_lane.mem[k][0]);
      end
      wr(ADDR_SEL, 8'h0d);
      rdc("bc_rd", 8'h00, 8'h31);
      wr(8'h03, 8'h77);
      wr(ADDR_SEL, 8'h0e);
      for (int k = 0; k < 4; k++) begin
         chk("bcast", 8'h77, u_lane.mem[k][3]);
         chk("sel_wr", 8'h00, u_lane.mem[k][255]);
      end
      rdc("bc_rd2", 8'h00, 8'h32);
      wr(ADDR_SEL, 8'h08);
      wr(ADDR_RSV2, 8'h3c);
      rdc("shared", ADDR_RSV2, 8'h3c);
      rdc("shared0", 8'h00, {STRAP, 4'h0});
      chk("no_lane", 8'h00, u_lane.mem[1][2]);
      wr(ADDR_CTL, 8'h21);
      wait_for(2, 1);
      rdc("bm_sc", ADDR_CTL, 8'h01);
      wr(ADDR_CTL, 8'h11);
      wait_for(0, 2);
      rdc("busy", ADDR_STAT, 8'h00);
      wait_for(1, 2);
      @(posedge clk_sys_i);
      rdc("done", ADDR_STAT, 8'h10);
      rdc("force_rw", ADDR_CTL, 8'h11);
      wr(ADDR_RSV2, 8'h5a);
      wr(ADDR_CTL, 8'h40);
      @(posedge clk_sys_i);
      rdc("soft_ctl", ADDR_CTL, 8'h01);
      rdc("soft_rsv2", ADDR_RSV2, 8'h00);
      chk("bm_once", 8'h01, 8'(cnt[2]));
      rst_n_i <= 1'b0;
      // new straps must be caught again after the second reset
      strap_addr_i <= 4'ha;
      repeat (2) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      @(posedge clk_sys_i);
      wr(ADDR_STAT, 8'h80);
      repeat (16) @(posedge clk_sys_i);
      chk("no_load", 8'h02, 8'(cnt[0]));
      rdc("dis_stat", ADDR_STAT, 8'h90);
      chk("bus_addr2", 8'h22, {1'b0, bus_addr_o});
      rdc("strap2", ADDR_STRAP, 8'ha0);
      report_and_stop;
   end
endmodule // shared_register_bank_channel_steering_test
